// file: rtl/pfsa_top.sv
// program flash self-access controller
//
// How it works
// - data low and high registers hold one 14-bit word for read and write
// - address low and high form a 10-bit word address, 000h to 3FFh
// - one word per read, four-word block per write
// - last word of block erases the row, then programs the block
// - erase and program times come from an internal timer
// - self read and write ignore the code-protect setting
// - write-protect select blocks writes to ranges; reads always allowed
// - code-protect active denies the serial programming port access
// - software writes of zero to read and write triggers are ignored
// - hardware clears read and write triggers when the operation ends
// - writes need write permit set; permit resets to zero
// - unlock register has no storage and reads as zero
// - unlock writes only arm the write sequence
// - data low register carries word bits 7 to 0
// - address low register carries address bits 7 to 0
// - array reached only through these registers, in normal execution
// - second instruction after read trigger does access; data next cycle
// - positions 0-2 only load buffer; position 3 erases 16, commits 4
// - address high keeps two bits; upper bits read zero
`timescale 1ns/10ps
module pfsa_top
#(
    parameter int unsigned ERASE_CYC = pfsa_pkg::ERASE_CYC,
    parameter int unsigned PROG_CYC  = pfsa_pkg::PROG_CYC
)
(
    input  wire logic                     CLOCK_I,
    input  wire logic                     RST_B_I,
    input  wire logic                     INSN_EN_I,
    input  wire pfsa_pkg::pfsa_sfr_req_s  SFR_REQ_I,
    output logic [7:0]                    SFR_RDATA_O,
    input  wire logic [13:0]              FLASH_RDATA_I,
    output pfsa_pkg::pfsa_flash_cmd_s     FLASH_O,
    output logic                          CPU_IGNORE_O,
    output logic                          CPU_HALT_O,
    input  wire logic [1:0]               WRITE_PROTECT_SELECT_I,
    input  wire logic                     CODE_PROTECT_N_I,
    input  wire logic                     SERPROG_REQ_I,
    output logic                          SERPROG_GRANT_O
);

    if (ERASE_CYC < 1 || ERASE_CYC >= (1 << pfsa_pkg::TIMER_W))
    begin : g_chk_erase
        $error("erase count does not fit the timer");
    end
    if (PROG_CYC < 1 || PROG_CYC >= (1 << pfsa_pkg::TIMER_W))
    begin : g_chk_prog
        $error("program count does not fit the timer");
    end

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RD_WAIT   = 3'b001,
        ST_RD_ACCESS = 3'b010,
        ST_WR_SETUP  = 3'b011,
        ST_ERASE     = 3'b100,
        ST_PROG      = 3'b101
    } pfsa_st_e;

    localparam int unsigned DW  = pfsa_pkg::DATA_W;
    localparam int unsigned AW  = pfsa_pkg::ADDR_W;
    localparam int unsigned DHW = pfsa_pkg::DATA_HI_W;
    localparam int unsigned AHW = pfsa_pkg::ADDR_HI_W;
    localparam int unsigned TW  = pfsa_pkg::TIMER_W;

    // is the address inside a write-protected range
    function automatic logic wp_blocks(input logic [1:0] sel, input logic [AW-1:0] a);
        logic r;
        r = 1'b0;
        case (sel)
            pfsa_pkg::WP_NONE:   r = 1'b0;
            pfsa_pkg::WP_LOW256: r = (a <= pfsa_pkg::WP_LOW256_TOP);
            pfsa_pkg::WP_LOW512: r = (a <= pfsa_pkg::WP_LOW512_TOP);
            default:             r = 1'b1;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register state
    pfsa_st_e                   state_q;
    pfsa_st_e                   state_d;
    logic [7:0]                 data_lo_q;
    logic [7:0]                 data_lo_d;
    logic [DHW-1:0]             data_hi_q;
    logic [DHW-1:0]             data_hi_d;
    logic [7:0]                 addr_lo_q;
    logic [7:0]                 addr_lo_d;
    logic [AHW-1:0]             addr_hi_q;
    logic [AHW-1:0]             addr_hi_d;
    logic                       permit_q;
    logic                       permit_d;
    logic                       rd_q;
    logic                       rd_d;
    logic                       wr_q;
    logic                       wr_d;
    logic [1:0]                 icnt_q;
    logic [1:0]                 icnt_d;
    logic [7:0]                 rdata_q;
    logic [7:0]                 rdata_d;
    logic [3:0][DW-1:0]         buf_q;
    logic [3:0][DW-1:0]         buf_d;

    logic                       sfr_wr;
    logic                       ctrl_wr;
    logic                       rd_set;
    logic                       wr_set;
    logic                       armed;
    logic                       wr_ok;
    logic [AW-1:0]              addr;
    logic [DW-1:0]              word;
    logic                       tmr_start;
    logic [TW-1:0]              tmr_load;
    logic                       tmr_done;

    assign sfr_wr  = SFR_REQ_I.wr;
    assign ctrl_wr = sfr_wr && SFR_REQ_I.sel == pfsa_pkg::SEL_CTRL;
    assign rd_set  = ctrl_wr && SFR_REQ_I.wdata[pfsa_pkg::CTRL_RD_BIT];
    assign wr_set  = ctrl_wr && SFR_REQ_I.wdata[pfsa_pkg::CTRL_WR_BIT];
    assign addr    = {addr_hi_q, addr_lo_q};
    assign word    = {data_hi_q, data_lo_q};
    // code protect deliberately not a term here
    assign wr_ok   = armed && permit_q
                     && !wp_blocks(WRITE_PROTECT_SELECT_I, addr);

    pfsa_unlock u_unlock
    (
        .clk_i       (CLOCK_I),
        .rst_b_i     (RST_B_I),
        .wr_i        (sfr_wr),
        .is_unlock_i (SFR_REQ_I.sel == pfsa_pkg::SEL_UNLOCK),
        .wdata_i     (SFR_REQ_I.wdata),
        .armed_o     (armed)
    );

    pfsa_timer #(.CNT_W(TW)) u_timer
    (
        .clk_i   (CLOCK_I),
        .rst_b_i (RST_B_I),
        .start_i (tmr_start),
        .load_i  (tmr_load),
        .busy_o  (),
        .done_o  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer and register file next state
    always_comb
    begin
        state_d   = state_q;
        data_lo_d = data_lo_q;
        data_hi_d = data_hi_q;
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        permit_d  = permit_q;
        rd_d      = rd_q;
        wr_d      = wr_q;
        icnt_d    = icnt_q;
        buf_d     = buf_q;
        tmr_start = 1'b0;
        tmr_load  = '0;
        // software writes
        if (sfr_wr)
        begin
            case (SFR_REQ_I.sel)
                pfsa_pkg::SEL_DATA_LO: data_lo_d = SFR_REQ_I.wdata;
                pfsa_pkg::SEL_DATA_HI: data_hi_d = SFR_REQ_I.wdata[DHW-1:0];
                pfsa_pkg::SEL_ADDR_LO: addr_lo_d = SFR_REQ_I.wdata;
                pfsa_pkg::SEL_ADDR_HI: addr_hi_d = SFR_REQ_I.wdata[AHW-1:0];
                pfsa_pkg::SEL_CTRL:    permit_d  = SFR_REQ_I.wdata[pfsa_pkg::CTRL_PERMIT_BIT];
                default:               permit_d  = permit_q;
            endcase
        end
        case (state_q)
            ST_IDLE:
            begin
                icnt_d = 2'h0;
                if (rd_set)
                begin
                    rd_d    = 1'b1;
                    state_d = ST_RD_WAIT;
                end
                else if (wr_set && wr_ok)
                begin
                    wr_d                   = 1'b1;
                    buf_d[addr_lo_q[1:0]]  = word;
                    state_d                = ST_WR_SETUP;
                end
            end
            ST_RD_WAIT:
            begin
                if (INSN_EN_I)
                begin
                    icnt_d = icnt_q + 2'h1;
                    if (icnt_q + 2'h1 == pfsa_pkg::READ_GAP_CYC)
                        state_d = ST_RD_ACCESS;
                end
            end
            ST_RD_ACCESS:
            begin
                if (INSN_EN_I)
                begin
                    data_lo_d = FLASH_RDATA_I[7:0];
                    data_hi_d = FLASH_RDATA_I[DW-1:8];
                    rd_d      = 1'b0;
                    state_d   = ST_IDLE;
                end
            end
            ST_WR_SETUP:
            begin
                if (INSN_EN_I)
                begin
                    icnt_d = icnt_q + 2'h1;
                    if (icnt_q + 2'h1 == pfsa_pkg::WR_SETUP_CYC)
                    begin
                        if (addr_lo_q[1:0] == pfsa_pkg::POS_LAST)
                        begin
                            tmr_start = 1'b1;
                            tmr_load  = TW'(ERASE_CYC);
                            state_d   = ST_ERASE;
                        end
                        else
                        begin
                            wr_d    = 1'b0;
                            state_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_ERASE:
            begin
                if (tmr_done)
                begin
                    tmr_start = 1'b1;
                    tmr_load  = TW'(PROG_CYC);
                    state_d   = ST_PROG;
                end
            end
            ST_PROG:
            begin
                if (tmr_done)
                begin
                    wr_d    = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                rd_d    = 1'b0;
                wr_d    = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back, registered
    always_comb
    begin
        rdata_d = rdata_q;
        if (SFR_REQ_I.rd)
        begin
            case (SFR_REQ_I.sel)
                pfsa_pkg::SEL_DATA_LO: rdata_d = data_lo_q;
                pfsa_pkg::SEL_DATA_HI: rdata_d = {{(8-DHW){1'b0}}, data_hi_q};
                pfsa_pkg::SEL_ADDR_LO: rdata_d = addr_lo_q;
                pfsa_pkg::SEL_ADDR_HI: rdata_d = {{(8-AHW){1'b0}}, addr_hi_q};
                pfsa_pkg::SEL_CTRL:    rdata_d = {5'h00, permit_q, wr_q, rd_q};
                default:               rdata_d = pfsa_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_q   <= ST_IDLE;
            data_lo_q <= pfsa_pkg::RST_BYTE;
            data_hi_q <= '0;
            addr_lo_q <= pfsa_pkg::RST_BYTE;
            addr_hi_q <= '0;
            permit_q  <= 1'b0;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            icnt_q    <= 2'h0;
            rdata_q   <= pfsa_pkg::RST_BYTE;
            buf_q     <= '0;
        end
        else
        begin
            state_q   <= state_d;
            data_lo_q <= data_lo_d;
            data_hi_q <= data_hi_d;
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            permit_q  <= permit_d;
            rd_q      <= rd_d;
            wr_q      <= wr_d;
            icnt_q    <= icnt_d;
            rdata_q   <= rdata_d;
            buf_q     <= buf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial programming port gate
    logic [2:0] sp_sync_q;
    logic [2:0] sp_sync_d;
    logic       sp_req_q;
    logic       sp_req_d;

    always_comb
    begin
        sp_sync_d = {sp_sync_q[1:0], SERPROG_REQ_I};
        sp_req_d  = sp_req_q;
        if (sp_sync_q[1] == sp_sync_q[2])
            sp_req_d = sp_sync_q[2];
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sp_sync_q <= 3'h0;
            sp_req_q  <= 1'b0;
        end
        else
        begin
            sp_sync_q <= sp_sync_d;
            sp_req_q  <= sp_req_d;
        end
    end

    assign SERPROG_GRANT_O = sp_req_q && CODE_PROTECT_N_I;

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the array and the core
    assign SFR_RDATA_O   = rdata_q;
    assign FLASH_O.rd    = (state_q == ST_RD_ACCESS);
    assign FLASH_O.erase = (state_q == ST_ERASE);
    assign FLASH_O.prog  = (state_q == ST_PROG);
    assign FLASH_O.addr  = (state_q == ST_ERASE) ? {addr[AW-1:pfsa_pkg::ROW_LSB], 4'h0} :
                           (state_q == ST_PROG)  ? {addr[AW-1:pfsa_pkg::BLOCK_LSB], 2'h0} :
                           addr;
    assign FLASH_O.words = buf_q;
    assign CPU_IGNORE_O  = (state_q == ST_RD_ACCESS);
    assign CPU_HALT_O    = (state_q == ST_ERASE) || (state_q == ST_PROG);

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_RD_HELD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        rd_q && state_q != ST_RD_ACCESS |=> rd_q)
        else $error("read trigger dropped early");
    AST_WR_HELD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        wr_q && (state_q == ST_ERASE || (state_q == ST_PROG && !tmr_done)) |=> wr_q)
        else $error("write trigger dropped during write");
    AST_RD_LATCH: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        state_q == ST_RD_ACCESS && INSN_EN_I
        |=> !rd_q && state_q == ST_IDLE && word == $past(FLASH_RDATA_I))
        else $error("read word not latched");
    AST_NO_PERMIT: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        state_q == ST_IDLE && wr_set && !rd_set && !permit_q |=> state_q == ST_IDLE && !wr_q)
        else $error("write started without permit");
    AST_LOCKED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        state_q == ST_IDLE && wr_set && !rd_set && !armed |=> !wr_q)
        else $error("write started without unlock");
    AST_UNLOCK_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        SFR_REQ_I.rd && SFR_REQ_I.sel == pfsa_pkg::SEL_UNLOCK |=> SFR_RDATA_O == 8'h00)
        else $error("unlock register read nonzero");
    AST_ADDR_HI: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        SFR_REQ_I.rd && SFR_REQ_I.sel == pfsa_pkg::SEL_ADDR_HI
        |=> SFR_RDATA_O == {6'h00, $past(addr_hi_q)})
        else $error("address high read wrong");
    AST_ERASE_PROG: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        $fell(FLASH_O.erase) |-> FLASH_O.prog && FLASH_O.addr[1:0] == 2'h0)
        else $error("erase not followed by program");
    AST_SP_DENY: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        !CODE_PROTECT_N_I |-> !SERPROG_GRANT_O)
        else $error("serial port granted under code protect");

endmodule

// file: rtl/pfsa_pkg.sv
// constants and types shared by the program flash self-access block
package pfsa_pkg;

    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned DATA_W        = 14;
    localparam int unsigned ADDR_W        = 10;
    localparam int unsigned DATA_HI_W     = DATA_W - BYTE_W;
    localparam int unsigned ADDR_HI_W     = ADDR_W - BYTE_W;
    localparam int unsigned BLOCK_WORDS   = 4;
    localparam int unsigned ROW_LSB       = 4;
    localparam int unsigned BLOCK_LSB     = 2;

    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND  = 8'hAA;
    localparam logic [1:0] POS_LAST       = 2'h3;

    localparam int unsigned CTRL_RD_BIT     = 0;
    localparam int unsigned CTRL_WR_BIT     = 1;
    localparam int unsigned CTRL_PERMIT_BIT = 2;

    // write-protect select codes and the top of each protected range
    localparam logic [1:0] WP_NONE        = 2'h3;
    localparam logic [1:0] WP_LOW256      = 2'h2;
    localparam logic [1:0] WP_LOW512      = 2'h1;
    localparam logic [9:0] WP_LOW256_TOP  = 10'h0FF;
    localparam logic [9:0] WP_LOW512_TOP  = 10'h1FF;

    // instruction cycles of read gap and write set-up
    localparam logic [1:0] READ_GAP_CYC   = 2'h2;
    localparam logic [1:0] WR_SETUP_CYC   = 2'h2;

    // self timing
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned ERASE_TIME_US = 4000;
    localparam int unsigned PROG_TIME_US  = 2000;
    localparam int unsigned ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
    localparam int unsigned PROG_CYC      = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned TIMER_W       = 18;

    typedef enum logic [2:0] {
        SEL_DATA_LO = 3'b000,
        SEL_DATA_HI = 3'b001,
        SEL_ADDR_LO = 3'b010,
        SEL_ADDR_HI = 3'b011,
        SEL_CTRL    = 3'b100,
        SEL_UNLOCK  = 3'b101
    } pfsa_sel_e;

    typedef struct packed {
        logic            wr;
        logic            rd;
        pfsa_sel_e       sel;
        logic [7:0]      wdata;
    } pfsa_sfr_req_s;

    typedef struct packed {
        logic                          rd;
        logic                          erase;
        logic                          prog;
        logic [ADDR_W-1:0]             addr;
        logic [BLOCK_WORDS-1:0][DATA_W-1:0] words;
    } pfsa_flash_cmd_s;

endpackage

// file: rtl/pfsa_unlock.sv
// unlock pattern tracker for the flash write sequence
`timescale 1ns/10ps
module pfsa_unlock
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       wr_i,
    input  wire logic       is_unlock_i,
    input  wire logic [7:0] wdata_i,
    output logic            armed_o
);

    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_GOT1  = 2'b01,
        UL_ARMED = 2'b10
    } pfsa_ul_e;

    pfsa_ul_e st_q;
    pfsa_ul_e st_d;

    ////////////////////////////////////////////////////////////////////////
    // any other register write drops the arm
    always_comb
    begin
        st_d = st_q;
        if (wr_i)
        begin
            if (!is_unlock_i)
                st_d = UL_IDLE;
            else if (wdata_i == pfsa_pkg::UNLOCK_FIRST)
                st_d = UL_GOT1;
            else if (wdata_i == pfsa_pkg::UNLOCK_SECOND && st_q == UL_GOT1)
                st_d = UL_ARMED;
            else
                st_d = UL_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st_q <= UL_IDLE;
        else
            st_q <= st_d;
    end

    assign armed_o = (st_q == UL_ARMED);

endmodule

// file: rtl/pfsa_timer.sv
// down-counter that times erase and program pulses
`timescale 1ns/10ps
module pfsa_timer
#(
    parameter int unsigned CNT_W = 18
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             start_i,
    input  wire logic [CNT_W-1:0] load_i,
    output logic                  busy_o,
    output logic                  done_o
);

    if (CNT_W < 2)
    begin : g_chk_width
        $error("timer width too small");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (start_i)
            cnt_d = load_i;
        else if (cnt_q != '0)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule

// file: dv/pfsa_flash_model.sv
// behavioural program flash array at the far side of the controller
`timescale 1ns/10ps
module pfsa_flash_model
(
    input  wire logic                      clk_i,
    input  wire pfsa_pkg::pfsa_flash_cmd_s cmd_i,
    output logic [13:0]                    rdata_o
);
    logic [13:0] mem [0:1023];
    logic        erase_q;
    logic        prog_q;
    initial
    begin
        for (int i = 0; i < 1024; i++)
            mem[i] = 14'(i);
    end
    ////////////////////////////////////////
    // word only while a read is asked, scrambled otherwise
    assign rdata_o = cmd_i.rd ? mem[cmd_i.addr] : ~mem[cmd_i.addr];
    // erase the row, then program the block, on each rising request
    always @(posedge clk_i)
    begin
        erase_q <= cmd_i.erase;
        prog_q  <= cmd_i.prog;
        if (cmd_i.erase && !erase_q)
            for (int i = 0; i < 16; i++)
                mem[{cmd_i.addr[9:4], 4'(i)}] = 14'h3FFF;
        if (cmd_i.prog && !prog_q)
            for (int i = 0; i < 4; i++)
                mem[{cmd_i.addr[9:2], 2'(i)}] = cmd_i.words[i];
    end
endmodule

// file: dv/tb.sv
// self-checking bench for the program flash self-access controller
`timescale 1ns/10ps
module tb;
    logic                      clk = 1'b0;
    logic                      rst_b;
    logic                      insn_en;
    pfsa_pkg::pfsa_sfr_req_s   req;
    logic [7:0]                rdata;
    logic [13:0]               frdata;
    pfsa_pkg::pfsa_flash_cmd_s fcmd;
    logic                      ignore;
    logic                      halt;
    logic [1:0]                wps;
    logic                      cp_n;
    logic                      sp_req;
    logic                      sp_grant;
    int                        fails;
    int                        n_compared;
    int                        cyc;
    int                        ign_seen;
    int                        halt_seen;
    int                        erase_cnt;
    logic [7:0]                v;
    ////////////////////////////////////////
    pfsa_top #(.ERASE_CYC(20), .PROG_CYC(10)) u_pfsa_top
    (
        .CLOCK_I                (clk),
        .RST_B_I                (rst_b),
        .INSN_EN_I              (insn_en),
        .SFR_REQ_I              (req),
        .SFR_RDATA_O            (rdata),
        .FLASH_RDATA_I          (frdata),
        .FLASH_O                (fcmd),
        .CPU_IGNORE_O           (ignore),
        .CPU_HALT_O             (halt),
        .WRITE_PROTECT_SELECT_I (wps),
        .CODE_PROTECT_N_I       (cp_n),
        .SERPROG_REQ_I          (sp_req),
        .SERPROG_GRANT_O        (sp_grant)
    );
    pfsa_flash_model u_pfsa_flash_model
    (
        .clk_i   (clk),
        .cmd_i   (fcmd),
        .rdata_o (frdata)
    );
    ////////////////////////////////////////
    always #10 clk = ~clk;
    // instruction boundary every fourth cycle
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        insn_en = (cyc % 4 == 0);
        // outputs counted where settled
        ign_seen = ign_seen + int'(ignore === 1'b1);
        halt_seen = halt_seen + int'(halt === 1'b1);
        erase_cnt = erase_cnt + int'(fcmd.erase === 1'b1);
    end
    ////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.sel = pfsa_pkg::pfsa_sel_e'(s);
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic get(input logic [2:0] s, output logic [7:0] d);
        @(negedge clk);
        req.rd = 1'b1;
        req.sel = pfsa_pkg::pfsa_sel_e'(s);
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        get(s, v);
        chk(v, e);
    endtask
    task automatic wait_done(input logic [7:0] m);
        for (int i = 0; i < 300; i++)
        begin
            get(3'h4, v);
            if ((v & m) === 8'h00)
                return;
        end
        fails = fails + 1;
        $display("unexpected at %0t: control trigger stuck", $time);
        report_and_stop();
    endtask
    task automatic put_addr(input logic [9:0] a);
        wr(3'h3, {6'h00, a[9:8]});
        wr(3'h2, a[7:0]);
    endtask
    task automatic flash_write(input logic [9:0] a, input logic [13:0] w, input logic [7:0] ec);
        put_addr(a);
        wr(3'h0, w[7:0]);
        wr(3'h1, {2'h0, w[13:8]});
        wr(3'h5, 8'h55);
        wr(3'h5, 8'hAA);
        wr(3'h4, 8'h06);
        if (ec !== 8'h00)
        begin
            wr(3'h4, 8'h04);
            rd(3'h4, ec);
        end
        wait_done(8'h02);
    endtask
    task automatic flash_read(input logic [9:0] a, input logic [13:0] w);
        put_addr(a);
        wr(3'h4, 8'h05);
        wait_done(8'h01);
        rd(3'h0, w[7:0]);
        rd(3'h1, {2'h0, w[13:8]});
    endtask
    ////////////////////////////////////////
    initial
    begin
        req = '0;
        rst_b = 1'b0;
        wps = 2'h2;
        cp_n = 1'b0;
        sp_req = 1'b0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        for (int s = 0; s < 6; s++)
            rd(3'(s), 8'h00);
        wr(3'h3, 8'hFF);
        rd(3'h3, 8'h03);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'h3F);
        wr(3'h0, 8'hA5);
        rd(3'h0, 8'hA5);
        wr(3'h5, 8'h55);
        rd(3'h5, 8'h00);
        wr(3'h6, 8'h77);
        rd(3'h6, 8'h00);
        wr(3'h5, 8'h55);
        wr(3'h5, 8'hAA);
        wr(3'h4, 8'h02);
        rd(3'h4, 8'h00);
        wr(3'h4, 8'h04);
        wr(3'h4, 8'h06);
        rd(3'h4, 8'h04);
        flash_write(10'h013, 14'h0BAD, 8'h04);
        flash_read(10'h013, 14'h0013);
        for (int i = 0; i < 3; i++)
            flash_write(10'h3F8 + 10'(i), 14'h1230 + 14'(i), 8'h00);
        chk(8'(halt_seen), 8'h00);
        flash_write(10'h3FB, 14'h1233, 8'h06);
        chk(8'(erase_cnt >= 20 && erase_cnt <= 21), 8'h01);
        chk(8'(halt_seen >= 30), 8'h01);
        flash_read(10'h3F9, 14'h1231);
        chk(8'(ign_seen), 8'h08);
        flash_read(10'h3F0, 14'h3FFF);
        flash_read(10'h3FB, 14'h1233);
        wps = 2'h3;
        flash_write(10'h010, 14'h0000, 8'h06);
        wps = 2'h1;
        flash_write(10'h1FC, 14'h0000, 8'h04);
        wps = 2'h0;
        flash_write(10'h3F8, 14'h0000, 8'h04);
        flash_read(10'h3F8, 14'h1230);
        sp_req = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, sp_grant}, 8'h00);
        cp_n = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, sp_grant}, 8'h01);
        report_and_stop();
    end
endmodule
